// ===== bench/seag_host_model.sv
`timescale 1ns/1ns
module seag_host_model
(
    input  wire logic        clk,
    input  wire logic [31:0] regRdata,
    input  wire logic        regAck,
    input  wire logic        regErr,
    output logic      [15:0] regAddr,
    output logic             regRead,
    output logic             regWrite,
    output logic      [31:0] regWdata
);
    initial
    begin
        regAddr = 16'h0000;
        regRead = 1'b0;
        regWrite = 1'b0;
        regWdata = 32'h00000000;
    end

    // Entered just after a falling edge; strobes are one-cycle pulses
    task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic e, output logic late);
        int n;
        regAddr = a;
        regWrite = wr;
        regRead = !wr;
        regWdata = d;
        late = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        regWrite = 1'b0;
        // Idle bus shows garbage so a design latching late is caught
        regAddr = ~a;
        regWdata = ~d;
        for (n = 0; n < 8; n++)
        begin
            if (regAck === 1'b1)
            begin
                q = regRdata;
                e = regErr;
                late = 1'b0;
                break;
            end
            @(negedge clk);
        end
        // One idle cycle so a following call never re-raises a strobe in this step
        @(negedge clk);
    endtask
endmodule

// ===== bench/seag_param_bank_monitor.sv
`timescale 1ns/1ns
module seag_param_bank_monitor
    import seag_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        ce,
    input wire logic [15:0] regAddr,
    input wire logic        regRead,
    input wire logic        regWrite,
    input wire logic [31:0] regWdata,
    input wire logic [31:0] regRdata,
    input wire logic        regAck,
    input wire logic        regErr,
    input wire logic        turnStepUp,
    input wire logic        turnStepDown,
    input wire logic        speedFromEncoder,
    input wire logic [15:0] positionGain,
    input wire logic [31:0] velocityFeedforward,
    input wire logic [31:0] accelFeedforward,
    input wire logic        defaultsActive,
    input wire logic        batteryErrorClear,
    input wire logic [15:0] turnCount
);
    wire take = ce && (regRead || regWrite);
    wire wrOp = take && regWrite;
    wire cmdWr = wrOp && regAddr == ADDR_MULTITURN_CMD;
    wire zeroCmd = cmdWr && regWdata == MT_CMD_ZERO_TURNS;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // ----------------------------------------
    // Register port, controller outputs and turn counter
    // ----------------------------------------
    ack_latency_a: assert property (take |=> regAck)
        else $error("request not acknowledged");
    reserved_zero_a: assert property (take && !regWrite && regAddr == ADDR_ALERT_FLAGS
        |=> regRdata[31:13] == 19'h0 && !regRdata[11]) else $error("reserved alert bit set");
    alert_write_a: assert property (wrOp && regAddr == ADDR_ALERT_FLAGS |=> !regErr)
        else $error("alert word write refused");
    gain_range_a: assert property (wrOp && regAddr == ADDR_POS_GAIN
        && regWdata > 32'h00002EE0 |=> regErr) else $error("gain above range accepted");
    speed_code_a: assert property (wrOp && regAddr == ADDR_SPEED_SOURCE
        && regWdata != 32'h0 && regWdata != 32'h3 |=> regErr) else $error("bad source accepted");
    // Signed view so that a negative value wrapping in is caught
    vel_bound_a: assert property ($signed(velocityFeedforward) >= -2000
        && $signed(velocityFeedforward) <= 2000) else $error("velocity feedforward out of range");
    defaults_out_a: assert property (defaultsActive [*2] |-> positionGain == 16'h012C
        && velocityFeedforward == 32'h1F4 && accelFeedforward == 32'h0 && !speedFromEncoder)
        else $error("factory values not applied");
    bat_clear_a: assert property (cmdWr && regWdata == 32'h1
        |=> batteryErrorClear && regAck && !regErr) else $error("battery clear missing");
    turn_zero_a: assert property (zeroCmd |=> turnCount == 16'h0000)
        else $error("turn count not zeroed");
    turn_step_a: assert property (ce && turnStepUp && !turnStepDown && !zeroCmd
        |=> turnCount == $past(turnCount) + 16'h0001) else $error("turn step lost");

    cover property (take && regRead && regAddr == ADDR_ALERT_FLAGS);
    cover property (batteryErrorClear);
    cover property (defaultsActive [*2]);
endmodule

bind seag_param_bank seag_param_bank_monitor seag_param_bank_monitor_inst (.clk(clk),
    .resetn(resetn), .ce(ce), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck), .regErr(regErr),
    .turnStepUp(turnStepUp), .turnStepDown(turnStepDown), .speedFromEncoder(speedFromEncoder),
    .positionGain(positionGain), .velocityFeedforward(velocityFeedforward),
    .accelFeedforward(accelFeedforward), .defaultsActive(defaultsActive),
    .batteryErrorClear(batteryErrorClear), .turnCount(turnCount));

// ===== bench/tb_servo_encoder_alert_gain_params.sv
`timescale 1ns/1ns
module tb_servo_encoder_alert_gain_params
    import seag_pkg::*;
;
    logic clk = 1'b0;
    logic resetn, ce, regRead, regWrite, regAck, regErr, motorConnectedPin;
    logic turnStepUp, turnStepDown, speedFromEncoder, defaultsActive, batteryErrorClear;
    logic [15:0] regAddr, batteryMillivolts, optimizedGain, positionGain, turnCount;
    logic [31:0] regWdata, regRdata, velocityFeedforward, accelFeedforward;
    logic [9:0] encoderAlertPins;
    int failures = 0;
    int cmp_count = 0;

    seag_param_bank seag_param_bank_inst (.clk(clk), .resetn(resetn), .ce(ce),
        .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata),
        .regRdata(regRdata), .regAck(regAck), .regErr(regErr),
        .encoderAlertPins(encoderAlertPins), .motorConnectedPin(motorConnectedPin),
        .batteryMillivolts(batteryMillivolts), .turnStepUp(turnStepUp),
        .turnStepDown(turnStepDown), .optimizedGain(optimizedGain),
        .speedFromEncoder(speedFromEncoder), .positionGain(positionGain),
        .velocityFeedforward(velocityFeedforward), .accelFeedforward(accelFeedforward),
        .defaultsActive(defaultsActive), .batteryErrorClear(batteryErrorClear),
        .turnCount(turnCount));
    seag_host_model seag_host_model_inst (.clk(clk), .regRdata(regRdata), .regAck(regAck),
        .regErr(regErr), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
        .regWdata(regWdata));

    always #25 clk = ~clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic e, input logic [31:0] x);
        logic [31:0] q;
        logic er, late;
        seag_host_model_inst.access(w, a, d, q, er, late);
        if (late)
        begin
            failures++;
            $display("mismatch at %0t: no acknowledge", $time);
            wrap_up();
        end
        else
        begin
            cmp({31'h0, er}, {31'h0, e});
            if (!w)
                cmp(q, x);
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] x);
        acc(1'b0, a, 32'h0, 1'b0, x);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic e);
        acc(1'b1, a, d, e, 32'h0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd(ADDR_SPEED_SOURCE, 32'h0);
        rd(ADDR_POS_GAIN, 32'h12C);
        rd(ADDR_VEL_FEEDFWD, 32'h1F4);
        rd(ADDR_ACC_FEEDFWD, 32'h0);
        acc(1'b0, 16'h0964, 32'h0, 1'b1, 32'h0);
    endtask

    task automatic t_ranges();
        wr(ADDR_POS_GAIN, 32'h2EE0, 1'b0);
        wr(ADDR_POS_GAIN, 32'h2EE1, 1'b1);
        rd(ADDR_POS_GAIN, 32'h2EE0);
        wr(ADDR_VEL_FEEDFWD, 32'hFFFFF830, 1'b0);
        wr(ADDR_VEL_FEEDFWD, 32'hFFFFF82F, 1'b1);
        wr(ADDR_VEL_FEEDFWD, 32'h7D1, 1'b1);
        rd(ADDR_VEL_FEEDFWD, 32'hFFFFF830);
        wr(ADDR_ACC_FEEDFWD, 32'h4E20, 1'b0);
        wr(ADDR_ACC_FEEDFWD, 32'hFFFFB1DF, 1'b1);
        rd(ADDR_ACC_FEEDFWD, 32'h4E20);
        wr(ADDR_SPEED_SOURCE, 32'h3, 1'b0);
        wr(ADDR_SPEED_SOURCE, 32'h1, 1'b1);
        rd(ADDR_SPEED_SOURCE, 32'h3);
        cmp({31'h0, speedFromEncoder}, 32'h1);
        cmp(accelFeedforward, 32'h4E20);
    endtask

    task automatic t_alerts();
        for (int n = 0; n < 10; n++)
        begin
            encoderAlertPins = 10'h001 << n;
            repeat (6) @(negedge clk);
            rd(ADDR_ALERT_FLAGS, 32'h1 << n);
            if (n == 6)
            begin
                cmp(velocityFeedforward, 32'h1F4);
                cmp({31'h0, speedFromEncoder}, 32'h0);
                rd(ADDR_VEL_FEEDFWD, 32'hFFFFF830);
            end
        end
        wr(ADDR_ALERT_FLAGS, 32'hFFFFFFFF, 1'b0);
        rd(ADDR_ALERT_FLAGS, 32'h200);
        encoderAlertPins = 10'h000;
        repeat (6) @(negedge clk);
        cmp(velocityFeedforward, 32'hFFFFF830);
    endtask

    task automatic t_battery();
        logic [15:0] mv [4] = '{16'h0BB7, 16'h0BB8, 16'h0C4E, 16'h0C4F};
        for (int n = 0; n < 4; n++)
        begin
            batteryMillivolts = mv[n];
            repeat (3) @(negedge clk);
            rd(ADDR_ALERT_FLAGS, (n == 1 || n == 2) ? 32'h400 : 32'h0);
        end
        batteryMillivolts = 16'h0000;
    endtask

    task automatic t_motor();
        optimizedGain = 16'h04D2;
        motorConnectedPin = 1'b1;
        repeat (8) @(negedge clk);
        rd(ADDR_POS_GAIN, 32'h4D2);
        cmp({16'h0, positionGain}, 32'h4D2);
    endtask

    task automatic t_turns();
        turnStepDown = 1'b1;
        @(negedge clk);
        turnStepDown = 1'b0;
        repeat (3) @(negedge clk);
        cmp({16'h0, turnCount}, 32'hFFFF);
        rd(ADDR_ALERT_FLAGS, 32'h0);
        turnStepUp = 1'b1;
        repeat (32769) @(negedge clk);
        turnStepUp = 1'b0;
        repeat (3) @(negedge clk);
        cmp({16'h0, turnCount}, 32'h8000);
        rd(ADDR_ALERT_FLAGS, 32'h1000);
        wr(ADDR_MULTITURN_CMD, 32'h2, 1'b0);
        cmp({16'h0, turnCount}, 32'h0);
        rd(ADDR_ALERT_FLAGS, 32'h0);
        wr(ADDR_MULTITURN_CMD, 32'h1, 1'b0);
        wr(ADDR_MULTITURN_CMD, 32'h0, 1'b0);
        wr(ADDR_MULTITURN_CMD, 32'h3, 1'b1);
        ce = 1'b0;
        turnStepUp = 1'b1;
        repeat (2) @(negedge clk);
        turnStepUp = 1'b0;
        ce = 1'b1;
        cmp({16'h0, turnCount}, 32'h0);
    endtask

    initial
    begin
        resetn = 1'b0;
        ce = 1'b1;
        encoderAlertPins = 10'h000;
        motorConnectedPin = 1'b0;
        batteryMillivolts = 16'h0000;
        turnStepUp = 1'b0;
        turnStepDown = 1'b0;
        optimizedGain = 16'h0000;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        t_reset();
        t_ranges();
        t_alerts();
        t_battery();
        t_motor();
        t_turns();
        wrap_up();
    end
endmodule

// ===== pkg/seag_pkg.sv
//
// Behaviour
// - Alert bit 0 flags encoder over-temperature, bit 1 under-temperature.
// - Alert bit 2 flags encoder over-speed, bit 3 over-acceleration.
// - Alert bit 4 flags bad storage checksum, bit 5 empty storage.
// - Invalid encoder parameter area sets alert bit 6; defaults then apply.
// - Alert bit 7 flags bad decoding sequence, bit 8 encoder flash fault.
// - Alert bit 9 flags unusually large shaft displacement.
// - Alert bit 10 set while battery lies within 3000 to 3150 mV.
// - Alert bit 12 latches when turn counter leaves signed range; command 2 clears.
// - Turn counter keeps counting as unsigned 16-bit value 0 to 65535.
// - Multi-turn command: 0 nothing, 1 clear battery error, 2 zero revolutions.
// - Speed source 0 computes feedback, 3 uses encoder speed; resets to 0.
// - Position gain unsigned 16-bit, accepts 0 to 12000, resets to 300.
// - Motor connection loads an optimised position gain over the current one.
// - Velocity feedforward signed 32-bit, accepts -2000 to 2000, resets to 500.
// - Acceleration feedforward signed 32-bit, accepts -20000 to 20000, resets to 0.
//
package seag_pkg;

    typedef logic [15:0] seag_addr_type;

    // ------------------------------------------------------------
    // Parameter addresses
    // ------------------------------------------------------------
    localparam seag_addr_type ADDR_MULTITURN_CMD  = 16'h0958;
    localparam seag_addr_type ADDR_ALERT_FLAGS    = 16'h0962;
    localparam seag_addr_type ADDR_SPEED_SOURCE   = 16'h0966;
    localparam seag_addr_type ADDR_POS_GAIN       = 16'h096A;
    localparam seag_addr_type ADDR_VEL_FEEDFWD    = 16'h096C;
    localparam seag_addr_type ADDR_ACC_FEEDFWD    = 16'h096E;

    // ------------------------------------------------------------
    // Alert word bit positions
    // ------------------------------------------------------------
    localparam int ALERT_PIN_COUNT    = 10;
    localparam int BIT_PARAM_INVALID  = 6;
    localparam int BIT_BATTERY_LOW    = 10;
    localparam int BIT_TURN_OVERRANGE = 12;

    // ------------------------------------------------------------
    // Reset values and accepted ranges
    // ------------------------------------------------------------
    localparam logic [1:0]  SPEED_SRC_COMPUTED = 2'h0;
    localparam logic [1:0]  SPEED_SRC_ENCODER  = 2'h3;
    localparam logic [15:0] POS_GAIN_RESET     = 16'h012C;
    localparam logic [31:0] POS_GAIN_MIN       = 32'h00000000;
    localparam logic [31:0] POS_GAIN_MAX       = 32'h00002EE0;
    localparam logic [31:0] VEL_FF_RESET       = 32'h000001F4;
    localparam logic [31:0] VEL_FF_MIN         = 32'hFFFFF830;
    localparam logic [31:0] VEL_FF_MAX         = 32'h000007D0;
    localparam logic [31:0] ACC_FF_RESET       = 32'h00000000;
    localparam logic [31:0] ACC_FF_MIN         = 32'hFFFFB1E0;
    localparam logic [31:0] ACC_FF_MAX         = 32'h00004E20;

    // ------------------------------------------------------------
    // Multi-turn commands and battery window
    // ------------------------------------------------------------
    localparam logic [31:0] MT_CMD_NONE        = 32'h00000000;
    localparam logic [31:0] MT_CMD_CLR_BATTERY = 32'h00000001;
    localparam logic [31:0] MT_CMD_ZERO_TURNS  = 32'h00000002;
    localparam logic [15:0] BATTERY_WARN_LO_MV = 16'h0BB8;
    localparam logic [15:0] BATTERY_WARN_HI_MV = 16'h0C4E;
    localparam int          TURN_WIDTH         = 16;

endpackage

// ===== verilog/seag_param_bank.sv
`timescale 1ns/1ns
module seag_param_bank
    import seag_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic                       ce,
    // ------------------------------------------------------------
    // Parameter access port
    // ------------------------------------------------------------
    input  wire logic [15:0]                regAddr,
    input  wire logic                       regRead,
    input  wire logic                       regWrite,
    input  wire logic [31:0]                regWdata,
    output logic      [31:0]                regRdata,
    output logic                            regAck,
    output logic                            regErr,
    // ------------------------------------------------------------
    // Encoder side
    // ------------------------------------------------------------
    input  wire logic [ALERT_PIN_COUNT-1:0] encoderAlertPins,
    input  wire logic                       motorConnectedPin,
    input  wire logic [15:0]                batteryMillivolts,
    input  wire logic                       turnStepUp,
    input  wire logic                       turnStepDown,
    input  wire logic [15:0]                optimizedGain,
    // ------------------------------------------------------------
    // Controller side
    // ------------------------------------------------------------
    output logic                            speedFromEncoder,
    output logic [15:0]                     positionGain,
    output logic [31:0]                     velocityFeedforward,
    output logic [31:0]                     accelFeedforward,
    output logic                            defaultsActive,
    output logic                            batteryErrorClear,
    output logic [TURN_WIDTH-1:0]           turnCount
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic inRange
    (
        input logic [31:0] value,
        input logic [31:0] low,
        input logic [31:0] high
    );
        inRange = ($signed(value) >= $signed(low)) && ($signed(value) <= $signed(high));
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [ALERT_PIN_COUNT:0] pinStable;

    seag_sync
    #(
        .WIDTH  (ALERT_PIN_COUNT + 1)
    )
    seag_sync_inst
    (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .pinIn  ({motorConnectedPin, encoderAlertPins}),
        .stable (pinStable)
    );

    wire [ALERT_PIN_COUNT-1:0] alertLevels  = pinStable[ALERT_PIN_COUNT-1:0];
    wire                       motorPresent = pinStable[ALERT_PIN_COUNT];

    // ------------------------------------------------------------
    // Stored parameters
    // ------------------------------------------------------------
    logic [1:0]  speedSource;
    logic [15:0] gainStored;
    logic [31:0] velFfStored;
    logic [31:0] accFfStored;
    logic        overrangeFlag;
    logic        motorPresentLast;
    logic        batteryWindow;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire hitCmd    = (regAddr == ADDR_MULTITURN_CMD);
    wire hitAlert  = (regAddr == ADDR_ALERT_FLAGS);
    wire hitSpeed  = (regAddr == ADDR_SPEED_SOURCE);
    wire hitGain   = (regAddr == ADDR_POS_GAIN);
    wire hitVelFf  = (regAddr == ADDR_VEL_FEEDFWD);
    wire hitAccFf  = (regAddr == ADDR_ACC_FEEDFWD);
    wire hitAny    = hitCmd | hitAlert | hitSpeed | hitGain | hitVelFf | hitAccFf;

    // ------------------------------------------------------------
    // Write qualification
    // ------------------------------------------------------------
    // An out-of-range value is refused whole; the old setting is kept
    wire speedValid = (regWdata == {30'h0, SPEED_SRC_COMPUTED})
                    | (regWdata == {30'h0, SPEED_SRC_ENCODER});
    wire gainValid  = inRange(regWdata, POS_GAIN_MIN, POS_GAIN_MAX);
    wire velValid   = inRange(regWdata, VEL_FF_MIN, VEL_FF_MAX);
    wire accValid   = inRange(regWdata, ACC_FF_MIN, ACC_FF_MAX);
    wire cmdValid   = inRange(regWdata, MT_CMD_NONE, MT_CMD_ZERO_TURNS);

    wire fieldValid = (hitSpeed & speedValid) | (hitGain & gainValid)
                    | (hitVelFf & velValid) | (hitAccFf & accValid)
                    | (hitCmd & cmdValid) | hitAlert;
    wire writeOk    = regWrite & hitAny & fieldValid;

    wire wrSpeed    = writeOk & hitSpeed;
    wire wrGain     = writeOk & hitGain;
    wire wrVelFf    = writeOk & hitVelFf;
    wire wrAccFf    = writeOk & hitAccFf;
    wire wrCmd      = writeOk & hitCmd;

    wire cmdZero    = wrCmd & (regWdata == MT_CMD_ZERO_TURNS);
    wire cmdBattery = wrCmd & (regWdata == MT_CMD_CLR_BATTERY);

    // ------------------------------------------------------------
    // Motor connection and turn counter
    // ------------------------------------------------------------
    wire motorAttach = motorPresent & ~motorPresentLast;
    wire turnLeft;

    seag_turn_counter
    #(
        .WIDTH      (TURN_WIDTH)
    )
    seag_turn_counter_inst
    (
        .clk        (clk),
        .resetn     (resetn),
        .ce         (ce),
        .stepUp     (turnStepUp),
        .stepDown   (turnStepDown),
        .clear      (cmdZero),
        .count      (turnCount),
        .leftSigned (turnLeft)
    );

    // Set wins over the clearing command in the same cycle
    wire next_overrange = turnLeft | (overrangeFlag & ~cmdZero);

    wire next_window = (batteryMillivolts >= BATTERY_WARN_LO_MV)
                     & (batteryMillivolts <= BATTERY_WARN_HI_MV);

    // ------------------------------------------------------------
    // Alert word
    // ------------------------------------------------------------
    logic [31:0] alertWord;

    always_comb
    begin
        alertWord                        = 32'h00000000;
        alertWord[ALERT_PIN_COUNT-1:0]   = alertLevels;
        alertWord[BIT_BATTERY_LOW]       = batteryWindow;
        alertWord[BIT_TURN_OVERRANGE]    = overrangeFlag;
    end

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    wire [31:0] readValue = hitAlert ? alertWord :
                            hitSpeed ? {30'h0, speedSource} :
                            hitGain  ? {16'h0, gainStored} :
                            hitVelFf ? velFfStored :
                            hitAccFf ? accFfStored :
                            32'h00000000;

    // ------------------------------------------------------------
    // Parameter storage
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            speedSource <= SPEED_SRC_COMPUTED;
            velFfStored <= VEL_FF_RESET;
            accFfStored <= ACC_FF_RESET;
        end
        else if (ce)
        begin
            if (wrSpeed)
            begin
                speedSource <= regWdata[1:0];
            end
            if (wrVelFf)
            begin
                velFfStored <= regWdata;
            end
            if (wrAccFf)
            begin
                accFfStored <= regWdata;
            end
        end
    end

    // Automatic tuning on attach takes priority over a host write
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gainStored       <= POS_GAIN_RESET;
            motorPresentLast <= 1'b0;
        end
        else if (ce)
        begin
            motorPresentLast <= motorPresent;
            if (motorAttach)
            begin
                gainStored <= optimizedGain;
            end
            else if (wrGain)
            begin
                gainStored <= regWdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Alert state
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            overrangeFlag <= 1'b0;
            batteryWindow <= 1'b0;
        end
        else if (ce)
        begin
            overrangeFlag <= next_overrange;
            batteryWindow <= next_window;
        end
    end

    // ------------------------------------------------------------
    // Controller outputs
    // ------------------------------------------------------------
    // While the encoder reports a bad parameter area the loops run on
    // factory values, but the host settings are kept for later
    wire paramInvalid = alertLevels[BIT_PARAM_INVALID];

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            speedFromEncoder    <= 1'b0;
            positionGain        <= POS_GAIN_RESET;
            velocityFeedforward <= VEL_FF_RESET;
            accelFeedforward    <= ACC_FF_RESET;
            defaultsActive      <= 1'b0;
            batteryErrorClear   <= 1'b0;
        end
        else if (ce)
        begin
            defaultsActive    <= paramInvalid;
            batteryErrorClear <= cmdBattery;
            if (paramInvalid)
            begin
                speedFromEncoder    <= 1'b0;
                positionGain        <= POS_GAIN_RESET;
                velocityFeedforward <= VEL_FF_RESET;
                accelFeedforward    <= ACC_FF_RESET;
            end
            else
            begin
                speedFromEncoder    <= (speedSource == SPEED_SRC_ENCODER);
                positionGain        <= gainStored;
                velocityFeedforward <= velFfStored;
                accelFeedforward    <= accFfStored;
            end
        end
    end

    // ------------------------------------------------------------
    // Access answer
    // ------------------------------------------------------------
    // One answer per request, one cycle later; an unmapped address or a
    // refused value answers with the error flag and zero data
    wire request = regRead | regWrite;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            regRdata <= 32'h00000000;
            regAck   <= 1'b0;
            regErr   <= 1'b0;
        end
        else if (ce)
        begin
            regAck <= request;
            regErr <= request & (~hitAny | (regWrite & ~fieldValid));
            if (regRead & hitAny)
            begin
                regRdata <= readValue;
            end
            else
            begin
                regRdata <= 32'h00000000;
            end
        end
    end

endmodule

// ===== verilog/seag_sync.sv
`timescale 1ns/1ns
module seag_sync
    import seag_pkg::*;
#(
    parameter int WIDTH = 11
)
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] stable
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);

    // A bit is taken only once the second and third stages agree
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            stable <= '0;
        end
        else if (ce)
        begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            stable <= (stage3 & agree) | (stable & ~agree);
        end
    end

endmodule

// ===== verilog/seag_turn_counter.sv
`timescale 1ns/1ns
module seag_turn_counter
    import seag_pkg::*;
#(
    parameter int WIDTH = TURN_WIDTH
)
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    input  wire logic             stepUp,
    input  wire logic             stepDown,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] count,
    output logic                  leftSigned
);

    localparam logic [WIDTH-1:0] SIGNED_MAX = {1'b0, {(WIDTH-1){1'b1}}};
    localparam logic [WIDTH-1:0] SIGNED_MIN = {1'b1, {(WIDTH-1){1'b0}}};
    localparam logic [WIDTH-1:0] ONE        = {{(WIDTH-1){1'b0}}, 1'b1};

    wire goUp   = stepUp & ~stepDown;
    wire goDown = stepDown & ~stepUp;
    // Crossing the signed limits in either direction
    wire crossing = (goUp & (count == SIGNED_MAX)) | (goDown & (count == SIGNED_MIN));

    wire [WIDTH-1:0] next_count = clear  ? '0 :
                                  goUp   ? count + ONE :
                                  goDown ? count - ONE : count;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count      <= '0;
            leftSigned <= 1'b0;
        end
        else if (ce)
        begin
            count      <= next_count;
            leftSigned <= crossing & ~clear;
        end
    end

endmodule
